// [hw/prio_regs_pkg.sv]
// Package: offsets, field layout and reset values of the priority registers.
// Assumes a 16-bit register port with one-cycle read latency.
package prio_regs_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int PRIO_W = 3;
    localparam int NUM_SRC = 6;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_PRIO_TWO   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_PRIO_THREE = 4'h1;

    // ------------------------------------------------------------------
    // Field positions (low bit of each field)
    // ------------------------------------------------------------------
    localparam int POS_SERIAL_RX = 12;
    localparam int POS_SPI_EVENT = 8;
    localparam int POS_SPI_FAULT = 4;
    localparam int POS_TIMER3    = 0;
    localparam int POS_CONV_DONE = 4;
    localparam int POS_SERIAL_TX = 0;

    // Implemented bit masks
    localparam logic [DATA_W-1:0] MASK_PRIO_TWO   = 16'h7777;
    localparam logic [DATA_W-1:0] MASK_PRIO_THREE = 16'h0077;

    // ------------------------------------------------------------------
    // Levels
    // ------------------------------------------------------------------
    localparam logic [PRIO_W-1:0] PRIO_RESET    = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_LOWEST   = 3'h1;
    localparam logic [PRIO_W-1:0] PRIO_HIGHEST  = 3'h7;

    // Source indices on the level bus
    localparam int SRC_SERIAL_RX = 0;
    localparam int SRC_SPI_EVENT = 1;
    localparam int SRC_SPI_FAULT = 2;
    localparam int SRC_TIMER3    = 3;
    localparam int SRC_CONV_DONE = 4;
    localparam int SRC_SERIAL_TX = 5;

endpackage

// [hw/prio_field_if.sv]
// Interface: priority levels and their enables passed between modules.
// Assumes the consumer runs on the same clock as the register file.
`timescale 1ns/1ps
interface prio_field_if
    import prio_regs_pkg::*;
();
    logic [NUM_SRC*PRIO_W-1:0] level;
    logic [NUM_SRC-1:0]        enabled;

    modport source (output level, input enabled);
    modport sink   (input level, output enabled);
endinterface

// [hw/prio_level_decode.sv]
// Decoder: marks which sources have a non-zero priority level.
// Assumes levels come straight from register flip-flops.
`timescale 1ns/1ps
module prio_level_decode
    import prio_regs_pkg::*;
(
    // Level bus
    prio_field_if.sink fields
);

    function automatic logic level_active(input logic [PRIO_W-1:0] lvl);
        return lvl != PRIO_DISABLED;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            // Zero level means source can never request service
            assign fields.enabled[g] =
                level_active(fields.level[g*PRIO_W +: PRIO_W]);
        end
    endgenerate

endmodule

// [hw/interrupt_priority_regs.sv]
// Top: two 16-bit priority control registers with a plain register port.
// Assumes one clock, synchronous reset, strobes never both high.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module interrupt_priority_regs
    import prio_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_sys_in,
    input  wire logic                      reset_in,
    // Register port
    input  wire logic [ADDR_W-1:0]         addr_in,
    input  wire logic [DATA_W-1:0]         wdata_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    output logic      [DATA_W-1:0]         rdata_out,
    // Priority levels to the arbiter
    output logic      [NUM_SRC*PRIO_W-1:0] level_out,
    output logic      [NUM_SRC-1:0]        enabled_out
);

    // ------------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------------
    logic [PRIO_W-1:0] serial_receive_priority_reg;
    logic [PRIO_W-1:0] spi_event_priority_reg;
    logic [PRIO_W-1:0] spi_fault_priority_reg;
    logic [PRIO_W-1:0] timer_three_priority_reg;
    logic [PRIO_W-1:0] conversion_done_priority_reg;
    logic [PRIO_W-1:0] serial_transmit_priority_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [NUM_SRC-1:0] enabled_reg;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic hit_two   = addr_in == OFF_PRIO_TWO;
    wire logic hit_three = addr_in == OFF_PRIO_THREE;
    wire logic wr_two    = wr_in && hit_two;
    wire logic wr_three  = wr_in && hit_three;

    // Packed views; empty bits are constant zero
    wire logic [DATA_W-1:0] view_two =
        {1'b0, serial_receive_priority_reg,
         1'b0, spi_event_priority_reg,
         1'b0, spi_fault_priority_reg,
         1'b0, timer_three_priority_reg};
    wire logic [DATA_W-1:0] view_three =
        {9'h000, conversion_done_priority_reg,
         1'b0, serial_transmit_priority_reg};

    wire logic [DATA_W-1:0] rdata_next =
        hit_two   ? (view_two & MASK_PRIO_TWO) :
        hit_three ? (view_three & MASK_PRIO_THREE) :
                    16'h0000;

    prio_field_if fields ();

    assign fields.level = {serial_transmit_priority_reg,
                           conversion_done_priority_reg,
                           timer_three_priority_reg,
                           spi_fault_priority_reg,
                           spi_event_priority_reg,
                           serial_receive_priority_reg};

    prio_level_decode u_decode (
        .fields (fields.sink)
    );

    // ------------------------------------------------------------------
    // Register two
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            serial_receive_priority_reg <= PRIO_RESET;
            spi_event_priority_reg      <= PRIO_RESET;
            spi_fault_priority_reg      <= PRIO_RESET;
            timer_three_priority_reg    <= PRIO_RESET;
        end else if (wr_two) begin
            serial_receive_priority_reg <=
                wdata_in[POS_SERIAL_RX +: PRIO_W];
            spi_event_priority_reg      <= wdata_in[POS_SPI_EVENT +: PRIO_W];
            spi_fault_priority_reg      <= wdata_in[POS_SPI_FAULT +: PRIO_W];
            timer_three_priority_reg    <= wdata_in[POS_TIMER3 +: PRIO_W];
        end
    end

    // ------------------------------------------------------------------
    // Register three
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            conversion_done_priority_reg <= PRIO_RESET;
            serial_transmit_priority_reg <= PRIO_RESET;
        end else if (wr_three) begin
            conversion_done_priority_reg <=
                wdata_in[POS_CONV_DONE +: PRIO_W];
            serial_transmit_priority_reg <=
                wdata_in[POS_SERIAL_TX +: PRIO_W];
        end
    end

    // ------------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rdata_reg   <= 16'h0000;
            enabled_reg <= '0;
        end else begin
            rdata_reg   <= rd_in ? rdata_next : 16'h0000;
            enabled_reg <= fields.enabled;
        end
    end

    assign rdata_out   = rdata_reg;
    assign level_out   = fields.level;
    assign enabled_out = enabled_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_write_two;
        wr_in && addr_in == OFF_PRIO_TWO;
    endsequence

    sequence s_read_two;
        rd_in && addr_in == OFF_PRIO_TWO;
    endsequence

    sequence s_write_three;
        wr_in && addr_in == OFF_PRIO_THREE;
    endsequence

    sequence s_read_three;
        rd_in && addr_in == OFF_PRIO_THREE;
    endsequence

    sequence s_write_unmapped;
        wr_in && !hit_two && !hit_three;
    endsequence

    property p_level_seven;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_two ##0 (wdata_in[14:12] == 3'h7) |=>
            level_out[2:0] == PRIO_HIGHEST;
    endproperty
    a_level_seven: assert property (p_level_seven)
        else $error("rx level not seven after write");

    property p_disabled;
        @(posedge clk_sys_in) disable iff (reset_in)
        (level_out[5:3] == PRIO_DISABLED) |=> !enabled_out[SRC_SPI_EVENT];
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("zero level source shown enabled");

    property p_lowest;
        @(posedge clk_sys_in) disable iff (reset_in)
        (level_out[8:6] == PRIO_LOWEST) |=> enabled_out[SRC_SPI_FAULT];
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("level one source not enabled");

    property p_empty_two;
        @(posedge clk_sys_in) disable iff (reset_in)
        rd_in |=> (rdata_out & ~MASK_PRIO_TWO) == 16'h0000;
    endproperty
    a_empty_two: assert property (p_empty_two)
        else $error("unimplemented bit reads one");

    property p_unmapped;
        @(posedge clk_sys_in) disable iff (reset_in)
        rd_in && !hit_two && !hit_three |=> rdata_out == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_round_two;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_two ##1 s_read_two |=>
            rdata_out == ($past(wdata_in, 2) & MASK_PRIO_TWO);
    endproperty
    a_round_two: assert property (p_round_two)
        else $error("register two readback mismatch");

    property p_three_fields;
        @(posedge clk_sys_in) disable iff (reset_in)
        wr_three |=> level_out[14:12] == $past(wdata_in[6:4]) &&
            level_out[17:15] == $past(wdata_in[2:0]);
    endproperty
    a_three_fields: assert property (p_three_fields)
        else $error("register three fields misplaced");

    property p_tx_hold;
        @(posedge clk_sys_in) disable iff (reset_in)
        !wr_three |=> $stable(serial_transmit_priority_reg);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit level changed without write");

    property p_reset_value;
        @(posedge clk_sys_in)
        reset_in |=> level_out == {NUM_SRC{PRIO_RESET}};
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("fields not level four after reset");

    property p_timer_seven;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_two ##0 (wdata_in[2:0] == 3'h7) |=>
            level_out[11:9] == PRIO_HIGHEST;
    endproperty
    a_timer_seven: assert property (p_timer_seven)
        else $error("timer level not seven after write");

    property p_rx_zero;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_two ##0 (wdata_in[14:12] == PRIO_DISABLED) |=>
            ##1 !enabled_out[SRC_SERIAL_RX];
    endproperty
    a_rx_zero: assert property (p_rx_zero)
        else $error("rx source enabled at level zero");

    property p_fault_one;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_two ##0 (wdata_in[6:4] == PRIO_LOWEST) |=>
            ##1 enabled_out[SRC_SPI_FAULT];
    endproperty
    a_fault_one: assert property (p_fault_one)
        else $error("level one fault source not enabled");

    property p_conv_enabled;
        @(posedge clk_sys_in) disable iff (reset_in)
        !reset_in && level_out[14:12] != PRIO_DISABLED |=>
            enabled_out[SRC_CONV_DONE];
    endproperty
    a_conv_enabled: assert property (p_conv_enabled)
        else $error("non-zero conversion level not enabled");

    property p_tx_disabled;
        @(posedge clk_sys_in) disable iff (reset_in)
        level_out[17:15] == PRIO_DISABLED |=> !enabled_out[SRC_SERIAL_TX];
    endproperty
    a_tx_disabled: assert property (p_tx_disabled)
        else $error("zero level transmit source enabled");

    property p_empty_three;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_read_three |=> (rdata_out & ~MASK_PRIO_THREE) == 16'h0000;
    endproperty
    a_empty_three: assert property (p_empty_three)
        else $error("register three empty bit reads one");

    property p_unmapped_write;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_unmapped |=> $stable(level_out);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("unmapped write changed a level");

    property p_two_fields;
        @(posedge clk_sys_in) disable iff (reset_in)
        wr_two |=> level_out[2:0] == $past(wdata_in[14:12]) &&
            level_out[5:3] == $past(wdata_in[10:8]) &&
            level_out[8:6] == $past(wdata_in[6:4]) &&
            level_out[11:9] == $past(wdata_in[2:0]);
    endproperty
    a_two_fields: assert property (p_two_fields)
        else $error("register two fields misplaced");

    property p_two_hold;
        @(posedge clk_sys_in) disable iff (reset_in)
        !wr_two |=> $stable(level_out[11:0]);
    endproperty
    a_two_hold: assert property (p_two_hold)
        else $error("register two level changed without write");

    property p_round_three;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_three ##1 s_read_three |=>
            rdata_out == ($past(wdata_in, 2) & MASK_PRIO_THREE);
    endproperty
    a_round_three: assert property (p_round_three)
        else $error("register three readback mismatch");

    property p_conv_hold;
        @(posedge clk_sys_in) disable iff (reset_in)
        !wr_three |=> $stable(conversion_done_priority_reg);
    endproperty
    a_conv_hold: assert property (p_conv_hold)
        else $error("conversion level changed without write");

    property p_tx_seven;
        @(posedge clk_sys_in) disable iff (reset_in)
        s_write_three ##0 (wdata_in[2:0] == 3'h7) |=>
            level_out[17:15] == PRIO_HIGHEST;
    endproperty
    a_tx_seven: assert property (p_tx_seven)
        else $error("transmit level not seven after write");

    property p_reset_enabled;
        @(posedge clk_sys_in)
        reset_in ##1 !reset_in |=> enabled_out == {NUM_SRC{1'b1}};
    endproperty
    a_reset_enabled: assert property (p_reset_enabled)
        else $error("sources not enabled after reset");

endmodule

// [dv/interrupt_priority_regs_bench.sv]
// Testbench: self-checking register and level tests for the priority regs.
// Assumes the package constants and a 100 MHz single-clock design.
`timescale 1ns/1ps
module interrupt_priority_regs_bench;
    import prio_regs_pkg::*;

    logic                      clk_sys_in = 1'b0;
    logic                      reset_in   = 1'b1;
    logic [ADDR_W-1:0]         addr_in    = '0;
    logic [DATA_W-1:0]         wdata_in   = '0;
    logic                      wr_in      = 1'b0;
    logic                      rd_in      = 1'b0;
    logic [DATA_W-1:0]         rdata_out;
    logic [NUM_SRC*PRIO_W-1:0] level_out;
    logic [NUM_SRC-1:0]        enabled_out;
    int                        num_errors = 0;
    int                        n_checks   = 0;
    logic [DATA_W-1:0]         two_m;
    logic [DATA_W-1:0]         three_m;

    interrupt_priority_regs interrupt_priority_regs_inst (
        .clk_sys_in  (clk_sys_in),
        .reset_in    (reset_in),
        .addr_in     (addr_in),
        .wdata_in    (wdata_in),
        .wr_in       (wr_in),
        .rd_in       (rd_in),
        .rdata_out   (rdata_out),
        .level_out   (level_out),
        .enabled_out (enabled_out)
    );

    always #5 clk_sys_in = ~clk_sys_in;

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic check_val(input string name, input logic [17:0] exp,
                             input logic [17:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clk_sys_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        wr_in    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        rd_in   <= 1'b0;
        #1;
        check_val("rdata_out", {2'h0, exp}, {2'h0, rdata_out});
    endtask

    // Write then read back with no gap between the strobes
    task automatic wr_rd(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d,
                         input logic [DATA_W-1:0] exp);
        @(posedge clk_sys_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        wr_in    <= 1'b0;
        rd_in    <= 1'b1;
        @(posedge clk_sys_in);
        rd_in    <= 1'b0;
        #1;
        check_val("rdata_out", {2'h0, exp}, {2'h0, rdata_out});
    endtask

    // Levels and enables expected from the mirrored register values
    task automatic check_outputs();
        logic [17:0] lvl;
        logic [17:0] en;
        lvl = {three_m[2:0], three_m[6:4], two_m[2:0],
               two_m[6:4], two_m[10:8], two_m[14:12]};
        en  = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            en[i] = |lvl[i*3 +: 3];
        end
        repeat (2) @(posedge clk_sys_in);
        #1;
        check_val("level_out", lvl, level_out);
        check_val("enabled_out", en, {12'h000, enabled_out});
    endtask

    task automatic put(input logic [DATA_W-1:0] t,
                       input logic [DATA_W-1:0] h);
        wr_reg(OFF_PRIO_TWO, t);
        wr_reg(OFF_PRIO_THREE, h);
        two_m   = t & 16'h7777;
        three_m = h & 16'h0077;
        rd_reg(OFF_PRIO_TWO, two_m);
        rd_reg(OFF_PRIO_THREE, three_m);
        check_outputs();
    endtask

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        two_m   = 16'h4444;
        three_m = 16'h0044;
        rd_reg(OFF_PRIO_TWO, 16'h4444);
        rd_reg(OFF_PRIO_THREE, 16'h0044);
        check_outputs();
        $display("Test reset_values done");

        put(16'hFFFF, 16'hFFFF);
        put(16'h1234, 16'hFF56);
        put(16'h8888, 16'hFF88);
        $display("Test field_layout done");

        for (int l = 0; l < 8; l++) begin
            put({4{1'b0, l[2:0]}},
                {8'hFF, 1'b1, l[2:0], 1'b1, l[2:0]});
        end
        $display("Test level_sweep done");

        put(16'h0070, 16'h0007);
        wr_reg(4'hF, 16'hFFFF);
        wr_reg(4'h2, 16'h0000);
        rd_reg(4'hF, 16'h0000);
        rd_reg(OFF_PRIO_TWO, two_m);
        rd_reg(OFF_PRIO_THREE, three_m);
        check_outputs();
        $display("Test unmapped_access done");

        wr_rd(OFF_PRIO_TWO, 16'hF531, 16'h7531);
        wr_rd(OFF_PRIO_THREE, 16'hFFE2, 16'h0062);
        two_m   = 16'h7531;
        three_m = 16'h0062;
        check_outputs();
        $display("Test back_to_back done");

        @(posedge clk_sys_in);
        reset_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        two_m   = 16'h4444;
        three_m = 16'h0044;
        rd_reg(OFF_PRIO_TWO, 16'h4444);
        rd_reg(OFF_PRIO_THREE, 16'h0044);
        check_outputs();
        $display("Test second_reset done");
        end_of_test();
    end
endmodule
